// File: rtl/emu_mem_pkg.sv
package emu_mem_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BLK_N = 16;
	localparam int BLK_AW = 14;
	localparam int BLK_SEL_W = 4;
	localparam int ATTR_W = 3;
	localparam int WORD_LSB = 2;
	localparam logic [31:0] FLASH_BASE = 32'h00000000;
	localparam logic [31:0] FLASH_SIZE = 32'h00040000;
	localparam logic [31:0] IO_BASE = 32'hFFFF8000;
	localparam logic [31:0] IO_SIZE = 32'h00008000;
	localparam logic [31:0] PC_STEP = 32'h00000002;
	localparam logic [2:0] RUN_FLASH_STATES = 3'h1;

	typedef enum logic [1:0] {
		REG_FLASH = 2'b00,
		REG_IO = 2'b01,
		REG_EXT = 2'b10
	} region_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic emu;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic done;
		logic [DATA_W-1:0] rdata;
	} bus_rsp_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_LOWPWR = 2'b01,
		ST_BREAK = 2'b10
	} run_state_t;
endpackage

// File: rtl/emulation_memory_break_control.sv
module emulation_memory_break_control #(
	parameter int FLASH_WORDS = 65536,
	parameter logic [2:0] EXT_ATTR_MAX = 3'h7
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// cpu bus
	input wire emu_mem_pkg::bus_req_t i_req,
	output emu_mem_pkg::bus_rsp_t o_rsp,
	// forwarding to real mcu i/o and external memory
	output emu_mem_pkg::bus_req_t o_io_req,
	input wire logic [emu_mem_pkg::DATA_W-1:0] i_io_rdata,
	output emu_mem_pkg::bus_req_t o_ext_req,
	output logic [emu_mem_pkg::ATTR_W-1:0] o_ext_attr,
	input wire logic [emu_mem_pkg::DATA_W-1:0] i_ext_rdata,
	// host debugger control
	input wire logic [emu_mem_pkg::BLK_N-1:0] i_ovl_enable,
	input wire logic [emu_mem_pkg::BLK_N-1:0][emu_mem_pkg::BLK_SEL_W-1:0] i_ovl_map,
	input wire logic [emu_mem_pkg::ATTR_W-1:0] i_ext_attr,
	input wire logic i_hw_break,
	input wire logic i_int_break,
	input wire logic i_restart,
	input wire logic i_step,
	// cpu status
	input wire logic i_sleep_enter,
	input wire logic [emu_mem_pkg::ADDR_W-1:0] i_pc,
	input wire logic i_wake,
	// user system
	input wire logic i_hw_standby_input_n,
	input wire logic i_irq,
	input wire logic i_port_supply_one,
	input wire logic i_port_supply_two,
	input wire logic i_vcc_ok,
	// to mcu core and trace
	output logic o_mcu_hw_standby_n,
	output logic o_break,
	output logic o_cpu_run,
	output logic [emu_mem_pkg::ADDR_W-1:0] o_resume_pc,
	output logic o_resume_valid,
	output logic o_irq_to_mcu,
	output logic o_trace_en,
	output logic o_user_present
);
	import emu_mem_pkg::*;

	localparam int FW_AW = $clog2(FLASH_WORDS);
	localparam int OVL_WORDS = BLK_N * (1 << (BLK_AW - WORD_LSB));
	localparam int OVL_AW = $clog2(OVL_WORDS);

	logic [DATA_W-1:0] flash_mem [FLASH_WORDS];
	logic [DATA_W-1:0] overlay_ram [OVL_WORDS];

	run_state_t state_reg, state_next;
	bus_rsp_t rsp_reg;
	bus_rsp_t rsp_next;
	logic [ADDR_W-1:0] resume_pc_reg;
	logic [ADDR_W-1:0] resume_pc_next;
	logic resume_valid_reg;
	logic resume_valid_next;
	logic irq_pend_reg;
	logic irq_pend_next;
	logic [ATTR_W-1:0] ext_attr_reg;
	logic [ATTR_W-1:0] ext_attr_next;

	// address decode
	wire in_flash = (i_req.addr - FLASH_BASE) < FLASH_SIZE;
	wire in_io = (i_req.addr - IO_BASE) < IO_SIZE;
	wire region_t region = in_flash ? REG_FLASH : (in_io ? REG_IO : REG_EXT);
	wire [BLK_SEL_W-1:0] flash_blk = i_req.addr[BLK_AW+BLK_SEL_W-1:BLK_AW];
	wire [BLK_AW-WORD_LSB-1:0] blk_word = i_req.addr[BLK_AW-1:WORD_LSB];

	// overlay hit search, one comparator per block
	logic [BLK_N-1:0] blk_hit;
	genvar g;
	generate
		for (g = 0; g < BLK_N; g++) begin : g_ovl
			assign blk_hit[g] = i_ovl_enable[g] && (i_ovl_map[g] == flash_blk);
		end
	endgenerate

	logic [BLK_SEL_W-1:0] hit_idx;
	always_comb begin
		hit_idx = '0;
		for (int k = BLK_N - 1; k >= 0; k--) begin
			if (blk_hit[k]) begin
				hit_idx = BLK_SEL_W'(k);
			end
		end
	end

	wire ovl_hit = |blk_hit;
	wire [OVL_AW-1:0] ovl_addr = OVL_AW'({hit_idx, blk_word});
	wire [FW_AW-1:0] flash_addr = i_req.addr[FW_AW+WORD_LSB-1:WORD_LSB];
	wire flash_acc = i_req.valid && (region == REG_FLASH);
	// user write without overlay is silently dropped; no break path exists
	wire ovl_wr = flash_acc && i_req.write && ovl_hit;
	wire flash_wr = flash_acc && i_req.write && !ovl_hit && i_req.emu;
	wire in_break = (state_reg == ST_BREAK);
	wire break_cond = i_hw_break || i_int_break;
	wire in_run = (state_reg == ST_RUN);
	wire in_lowpwr = (state_reg == ST_LOWPWR);
	// an interrupt also ends low power, as it would on the real part
	wire wake_src = i_wake || i_irq;
	wire leave_break = i_restart || i_step;
	wire sleep_take = in_run && i_sleep_enter;
	wire lowpwr_break = in_lowpwr && break_cond;
	wire restart_take = in_break && leave_break;

	// single-state flash and overlay access
	always_ff @(posedge i_clk) begin
		if (ovl_wr) begin
			overlay_ram[ovl_addr] <= i_req.wdata;
		end
	end
	always_ff @(posedge i_clk) begin
		if (flash_wr) begin
			flash_mem[flash_addr] <= i_req.wdata;
		end
	end

	wire [DATA_W-1:0] flash_rd = ovl_hit ? overlay_ram[ovl_addr] : flash_mem[flash_addr];
	wire [DATA_W-1:0] rdata_sel = (region == REG_FLASH) ? flash_rd :
		(region == REG_IO) ? i_io_rdata : i_ext_rdata;
	// done and its data are registered together so they never part
	assign rsp_next.done = i_req.valid;
	assign rsp_next.rdata = rdata_sel;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end
	assign o_rsp = rsp_reg;

	// i/o goes to the real mcu; no break source here
	assign o_io_req = (region == REG_IO) ? i_req : '0;
	assign o_ext_req = (region == REG_EXT) ? i_req : '0;

	// any attribute up to the supported maximum is accepted
	wire attr_ok = (i_ext_attr <= EXT_ATTR_MAX);
	assign ext_attr_next = attr_ok ? i_ext_attr : ext_attr_reg;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_attr_reg <= '0;
		end else begin
			ext_attr_reg <= ext_attr_next;
		end
	end
	assign o_ext_attr = ext_attr_reg;

	// run / low-power / break sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (break_cond) begin
					state_next = ST_BREAK;
				end else if (i_sleep_enter) begin
					state_next = ST_LOWPWR;
				end
			end
			ST_LOWPWR: begin
				if (break_cond) begin
					state_next = ST_BREAK;
				end else if (wake_src) begin
					state_next = ST_RUN;
				end
			end
			ST_BREAK: begin
				if (leave_break) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// capture the resume point on sleep entry; mark it valid when the sleep is broken
	assign resume_pc_next = sleep_take ? i_pc + PC_STEP : resume_pc_reg;
	assign resume_valid_next = lowpwr_break || (resume_valid_reg && !restart_take);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			resume_pc_reg <= '0;
		end else begin
			resume_pc_reg <= resume_pc_next;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			resume_valid_reg <= 1'b0;
		end else begin
			resume_valid_reg <= resume_valid_next;
		end
	end
	assign o_resume_pc = resume_pc_reg;
	assign o_resume_valid = resume_valid_reg && in_break;

	// interrupts held across break, released on restart or step
	assign irq_pend_next = in_break && (irq_pend_reg || i_irq);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_pend_reg <= 1'b0;
		end else begin
			irq_pend_reg <= irq_pend_next;
		end
	end
	assign o_irq_to_mcu = !in_break && (i_irq || irq_pend_reg);

	assign o_break = in_break;
	assign o_cpu_run = !in_break;
	assign o_trace_en = (state_reg == ST_RUN);
	// standby pin from the user board is deliberately not passed through
	assign o_mcu_hw_standby_n = 1'b1;
	assign o_user_present = i_vcc_ok && i_port_supply_one && i_port_supply_two;

	wire unused_ok = i_hw_standby_input_n;
endmodule

// File: verif/emu_chk_sva.sv
module emu_chk (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// bus
	input wire emu_mem_pkg::bus_req_t i_req,
	input wire emu_mem_pkg::bus_rsp_t o_rsp,
	input wire emu_mem_pkg::bus_req_t o_io_req,
	input wire emu_mem_pkg::bus_req_t o_ext_req,
	// control
	input wire logic i_hw_break,
	input wire logic i_restart,
	input wire logic i_step,
	input wire logic i_sleep_enter,
	input wire logic i_irq,
	// status
	input wire logic o_mcu_hw_standby_n,
	input wire logic o_break,
	input wire logic o_resume_valid,
	input wire logic o_irq_to_mcu,
	input wire logic o_trace_en
);
	timeunit 1ns;
	timeprecision 100ps;
	import emu_mem_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	AST_DONE: assert property (i_req.valid |=> o_rsp.done) else $error("no done");
	AST_IDLE: assert property (!i_req.valid |=> !o_rsp.done) else $error("stray done");
	AST_IO: assert property (i_req.addr >= IO_BASE |-> o_io_req == i_req) else $error("io");
	AST_EXT: assert property ((i_req.addr - FLASH_BASE) >= FLASH_SIZE && i_req.addr < IO_BASE
		|-> o_ext_req == i_req) else $error("ext");
	AST_HW_STANDBY_INPUT_N: assert property (o_mcu_hw_standby_n) else $error("standby");
	AST_LP: assert property (o_trace_en && i_sleep_enter |=> !o_trace_en) else $error("trace");
	AST_LPBRK: assert property (!o_trace_en && !o_break && i_hw_break
		|=> o_break && o_resume_valid) else $error("lp break");
	AST_GO: assert property (o_break && (i_restart || i_step)
		|=> o_trace_en) else $error("no restart");
	AST_MUTE: assert property (o_break |-> !o_irq_to_mcu) else $error("irq in break");
	AST_HELD: assert property ((o_break && i_irq) ##1 (o_break && (i_restart || i_step))
		|=> o_irq_to_mcu) else $error("irq lost");
	AST_IRQ: assert property (o_trace_en && i_irq |-> o_irq_to_mcu) else $error("irq");
	cover property (o_resume_valid);
	cover property (o_break && i_irq);
	cover property (o_rsp.done && i_req.valid);
	cover property ((!o_trace_en && !o_break) ##1 o_trace_en);
endmodule
bind emulation_memory_break_control emu_chk chk_i(.*);

// File: verif/user_board.sv
module user_board (
	// bus from the emulator
	input wire logic i_clk,
	input wire emu_mem_pkg::bus_req_t i_io_req,
	input wire emu_mem_pkg::bus_req_t i_ext_req,
	// read data back
	output logic [31:0] o_io_rdata,
	output logic [31:0] o_ext_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] junk = 32'h5A5A5A5A;
	// unselected bus must not look like stale read data
	always @(posedge i_clk) junk <= ~junk;
	assign o_io_rdata = i_io_req.valid ? {i_io_req.addr[15:0], 16'hA5A5} : junk;
	assign o_ext_rdata = i_ext_req.valid ? {i_ext_req.addr[15:0], 16'h5A5A} : junk;
endmodule

// File: verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import emu_mem_pkg::*;
	logic i_clk = 0, i_rst_b = 0, i_hw_break = 0, i_int_break = 0, i_restart = 0;
	logic i_step = 0, i_sleep_enter = 0, i_wake = 0, i_irq = 0, i_vcc_ok = 1;
	logic i_hw_standby_input_n = 1, i_port_supply_one = 1, i_port_supply_two = 1;
	logic o_mcu_hw_standby_n, o_break, o_cpu_run, o_resume_valid, o_irq_to_mcu;
	logic o_trace_en, o_user_present;
	logic [15:0] i_ovl_enable = 0;
	logic [15:0][3:0] i_ovl_map = 0;
	logic [2:0] i_ext_attr = 0, o_ext_attr;
	logic [31:0] i_pc = 0, i_io_rdata, i_ext_rdata, o_resume_pc, rd;
	bus_req_t i_req = 0, o_io_req, o_ext_req;
	bus_rsp_t o_rsp;
	int err_count = 0, checked = 0;
	emulation_memory_break_control DUT(.*);
	user_board board(.i_clk, .i_io_req(o_io_req), .i_ext_req(o_ext_req),
		.o_io_rdata(i_io_rdata), .o_ext_rdata(i_ext_rdata));
	initial forever #12.5 i_clk = ~i_clk;
	task automatic chk(string n, logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge i_clk);
		s = 0;
	endtask
	task automatic acc(logic w, e, logic [31:0] a, d = 0);
		i_req = {1'b1, w, e, a, d};
		@(negedge i_clk);
		i_req.valid = 0;
		rd = o_rsp.rdata;
		chk("done", 1, o_rsp.done);
		@(negedge i_clk);
	endtask
	task automatic t_mem();
		acc(1, 1, 32'h00004000, 32'h1111AAAA);
		acc(1, 0, 32'h00004000, 32'h2222BBBB);
		acc(0, 0, 32'h00004000);
		chk("flash", 32'h1111AAAA, rd);
		chk("brk", 0, o_break);
		i_ovl_map[3] = 4'h1;
		i_ovl_enable = 16'h0008;
		acc(1, 0, 32'h00004004, 32'h3333CCCC);
		acc(0, 0, 32'h00004004);
		chk("ovl", 32'h3333CCCC, rd);
		chk("brk", 0, o_break);
		i_ovl_enable = 0;
		acc(0, 1, 32'h00004000);
		chk("flash", 32'h1111AAAA, rd);
		$display("t_mem end");
	endtask
	task automatic t_fwd();
		acc(0, 0, 32'hFFFF8010);
		chk("io", 32'h8010A5A5, rd);
		acc(1, 0, 32'hFFFF8010, 32'h00000001);
		chk("brk", 0, o_break);
		acc(0, 0, 32'h10000020);
		chk("ext", 32'h00205A5A, rd);
		for (int a = 0; a < 8; a++) begin
			i_ext_attr = a[2:0];
			@(negedge i_clk);
			chk("attr", a, o_ext_attr);
		end
		$display("t_fwd end");
	endtask
	task automatic t_lp();
		i_pc = 32'h00001230;
		pulse(i_sleep_enter);
		chk("trace", 0, o_trace_en);
		pulse(i_wake);
		chk("wake", 1, o_trace_en);
		pulse(i_sleep_enter);
		pulse(i_hw_break);
		chk("brk", 1, o_break);
		chk("rv", 1, o_resume_valid);
		chk("pc", 32'h00001230 + PC_STEP, o_resume_pc);
		pulse(i_restart);
		chk("run", 1, o_cpu_run);
		$display("t_lp end");
	endtask
	task automatic t_irq();
		i_irq = 1;
		@(negedge i_clk);
		chk("irq", 1, o_irq_to_mcu);
		i_irq = 0;
		pulse(i_int_break);
		pulse(i_irq);
		chk("mute", 0, o_irq_to_mcu);
		pulse(i_step);
		chk("held", 1, o_irq_to_mcu);
		$display("t_irq end");
	endtask
	task automatic t_sup();
		for (int i = 0; i < 8; i++) begin
			{i_port_supply_one, i_port_supply_two, i_vcc_ok} = i[2:0];
			i_hw_standby_input_n = i[0];
			@(negedge i_clk);
			chk("present", i == 7, o_user_present);
			chk("standby", 1, o_mcu_hw_standby_n);
		end
		$display("t_sup end");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5000) @(negedge i_clk);
		err_count++;
		summarize();
	end
	initial begin
		repeat (20) @(negedge i_clk);
		i_rst_b = 1;
		@(negedge i_clk);
		t_mem();
		t_fwd();
		t_lp();
		t_irq();
		t_sup();
		summarize();
	end
endmodule
